//--- inc/cws_map.svh
// Register offsets, field positions and timing constants of the control write sequencer
`ifndef CWS_MAP_SVH
`define CWS_MAP_SVH
`define CWS_OFS_ENA 8'h6C
`define CWS_OFS_LAUNCH 8'h6F
`define CWS_OFS_STAT 8'h70
`define CWS_BIT_ENA 8
`define CWS_BIT_LAUNCH 8
`define CWS_BIT_CANCEL 9
`define CWS_BIT_BUSY 0
`define CWS_PTR_LSB 4
`define CWS_WIDX_MSB 4
`define CWS_FIRST_MSB 5
`define CWS_RAM_LAST 6'h1F
`define CWS_MEM_DEPTH 64
`define CWS_DUMMY_REG 8'hFF
`define CWS_K_NS 62500
`define CWS_CLK_NS 40
`define CWS_K_CYCLES ((`CWS_K_NS + `CWS_CLK_NS - 1) / `CWS_CLK_NS)
`define CWS_WAIT_BASE 16'h0008
`endif

//--- inc/cws_pkg.sv
// Types shared by the control write sequencer
package cws_pkg;
  typedef enum logic [3:0] {
    CWS_IDLE  = 4'h1,
    CWS_FETCH = 4'h2,
    CWS_WRITE = 4'h4,
    CWS_WAIT  = 4'h8
  } cws_fsm_t;

  typedef struct packed {
    logic last;
    logic [3:0] wait_code;
    logic [2:0] width;
    logic [3:0] lsb;
    logic [7:0] target;
    logic [7:0] value;
  } cws_step_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cws_host_wr_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] data;
    logic [15:0] mask;
  } cws_ctrl_wr_t;

  typedef struct packed {
    cws_fsm_t fsm;
    logic ena;
    logic [4:0] wr_index;
    logic launch;
    logic [5:0] first;
    logic [5:0] ptr;
    logic busy;
    cws_step_t cur;
    logic [15:0] units;
    logic [15:0] ticks;
    cws_ctrl_wr_t ctrl;
    logic done;
    logic lock;
    logic [7:0] last_addr;
    logic lsb_phase;
    logic [7:0] rd_byte;
    logic rd_vld;
  } cws_state_t;
endpackage

//--- src/cws_sequencer.sv
// Control write sequencer with its register slice and byte readback path
// Operation
// [RULE_01] Each step fetches its stored field description and writes it to the target register.
// [RULE_02] Steps advance through consecutive locations until a last-marked step, then halt and flag done.
// [RULE_03] A per-step wait follows each step, set by that step's wait code.
// [RULE_04] Sequencer runs on the system clock; host keeps clock present and enabled.
// [RULE_05] Sequencer advances only while enable bit 8 of 6Ch is set; resets off. Here the write stage still issues its write and moves on with enable clear.
// [RULE_06] Host loads first step, writes launch bit 8 of 6Fh; run begins there.
// [RULE_07] Launch bit clears itself when the last-marked step completes.
// [RULE_08] First step field is bits 5:0; 0-31 RAM, 32-48 ROM, 49-63 reserved.
// [RULE_09] Writing cancel bit 9 of 6Fh stops the run, returns control to host.
// [RULE_10] Running flag at bit 0 of 70h reads 1 during a run, else 0.
// [RULE_11] While running, ordinary host register access is locked; sequencer registers stay open.
// [RULE_12] Bits 9:4 of 70h show the last accessed step, holding final step afterwards.
// [RULE_13] Reaching the end raises the done event for the interrupt status register.
// [RULE_14] Reads without address return MSB then LSB, auto-incrementing from last address.
// [RULE_15] Only the coded width of data bits is written at the stored LSB position.
// [RULE_16] Each step lasts 62.5 us times two to the wait code plus eight.
// [RULE_17] A last-marked step stops the sequencer after it executes.
// [RULE_18] Cancel clears running and launch after any write, keeping the step pointer.
`timescale 1ns/1ps
`include "cws_map.svh"
module cws_sequencer #(
  parameter int K_CYCLES = `CWS_K_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SYS_CLK_ENA,
  input wire cws_pkg::cws_host_wr_t HOST_WR,
  input wire logic RD_ADDR_SET,
  input wire logic RD_BYTE_REQ,
  input wire logic [15:0] MAP_RD_DATA,
  input wire logic STEP_LOAD,
  input wire cws_pkg::cws_step_t STEP_DESC,
  output logic [7:0] MAP_RD_ADDR,
  output logic [7:0] RD_BYTE,
  output logic RD_BYTE_VLD,
  output cws_pkg::cws_ctrl_wr_t CTRL_WR,
  output logic HOST_LOCK,
  output logic SEQ_DONE_EVENT
);
  import cws_pkg::*;

  localparam logic [15:0] K_LAST = 16'(K_CYCLES - 1);
  localparam cws_step_t DUMMY_STEP = '{last: 1'b1, wait_code: 4'h0, width: 3'h0, lsb: 4'h0,
                                        target: `CWS_DUMMY_REG, value: 8'h00};

  cws_state_t s_q;
  cws_state_t s_d;
  cws_step_t mem [`CWS_MEM_DEPTH];
  cws_step_t fetched;
  logic [15:0] rd_word;
  logic [16:0] low_mask;
  logic [15:0] step_units;
  logic run_ok;
  logic wr_launch;
  logic wr_ena;

  // Step memory: RAM part loadable, ROM and reserved part read as a last-marked dummy write
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < `CWS_MEM_DEPTH; i++)
      begin
        mem[i] <= DUMMY_STEP;
      end
    end
    else if (STEP_LOAD)
    begin
      mem[STEP_DESC.target[4:0]] <= STEP_DESC; // Index travels in target low bits during load
    end
  end

  // Decodes and derived step quantities
  always_comb
  begin
    fetched = (s_q.ptr > `CWS_RAM_LAST) ? DUMMY_STEP : mem[s_q.ptr]; // RULE_08
    run_ok = s_q.ena && SYS_CLK_ENA; // RULE_04 RULE_05
    wr_launch = HOST_WR.wr && (HOST_WR.addr == `CWS_OFS_LAUNCH);
    wr_ena = HOST_WR.wr && (HOST_WR.addr == `CWS_OFS_ENA);
    // Widened before the add so that width code 7 gives a shift of eight, not zero
    low_mask = (17'h00001 << ({1'b0, s_q.cur.width} + 4'h1)) - 17'h00001; // RULE_15
    step_units = (16'h0001 << s_q.cur.wait_code) + `CWS_WAIT_BASE; // RULE_16
    case (s_q.last_addr)
      `CWS_OFS_ENA: rd_word = {7'h00, s_q.ena, 3'h0, s_q.wr_index};
      `CWS_OFS_LAUNCH: rd_word = {7'h00, s_q.launch, 2'h0, s_q.first};
      `CWS_OFS_STAT: rd_word = {6'h00, s_q.ptr, 3'h0, s_q.busy}; // RULE_10 RULE_12
      default: rd_word = MAP_RD_DATA;
    endcase
  end

  // Next-state logic
  always_comb
  begin
    s_d = s_q;
    s_d.ctrl.wr = 1'b0;
    s_d.done = 1'b0;
    s_d.rd_vld = 1'b0;
    if (wr_ena)
    begin
      s_d.ena = HOST_WR.wdata[`CWS_BIT_ENA];
      s_d.wr_index = HOST_WR.wdata[`CWS_WIDX_MSB:0];
    end
    if (wr_launch)
    begin
      s_d.first = HOST_WR.wdata[`CWS_FIRST_MSB:0]; // RULE_08
    end
    // Readback path: address set or write sets last address, requests alternate bytes
    if (RD_ADDR_SET || HOST_WR.wr)
    begin
      s_d.last_addr = HOST_WR.addr;
      s_d.lsb_phase = 1'b0;
    end
    else if (RD_BYTE_REQ)
    begin
      s_d.rd_vld = 1'b1;
      s_d.rd_byte = s_q.lsb_phase ? rd_word[7:0] : rd_word[15:8]; // RULE_14
      s_d.lsb_phase = ~s_q.lsb_phase;
      if (s_q.lsb_phase)
      begin
        s_d.last_addr = s_q.last_addr + 8'h01; // RULE_14
      end
    end
    case (s_q.fsm)
      CWS_IDLE:
      begin
        if (wr_launch && HOST_WR.wdata[`CWS_BIT_LAUNCH] && !HOST_WR.wdata[`CWS_BIT_CANCEL])
        begin
          s_d.launch = 1'b1; // RULE_06
          s_d.busy = 1'b1;
          s_d.ptr = HOST_WR.wdata[`CWS_FIRST_MSB:0];
          s_d.fsm = CWS_FETCH;
        end
      end
      CWS_FETCH:
      begin
        if (run_ok)
        begin
          s_d.cur = fetched; // RULE_01
          s_d.units = '0;
          s_d.ticks = '0;
          s_d.fsm = CWS_WRITE;
        end
      end
      CWS_WRITE:
      begin
        s_d.ctrl.wr = 1'b1; // RULE_01
        s_d.ctrl.addr = s_q.cur.target;
        s_d.ctrl.mask = 16'(low_mask << s_q.cur.lsb); // RULE_15
        s_d.ctrl.data = 16'(({9'h000, s_q.cur.value} & low_mask) << s_q.cur.lsb); // RULE_15
        s_d.fsm = CWS_WAIT;
      end
      CWS_WAIT:
      begin
        if (run_ok)
        begin
          s_d.ticks = (s_q.ticks == K_LAST) ? '0 : s_q.ticks + 16'h0001; // RULE_03
          if (s_q.ticks == K_LAST)
          begin
            s_d.units = s_q.units + 16'h0001;
            if (s_q.units == step_units - 16'h0001) // RULE_16
            begin
              if (s_q.cur.last)
              begin
                s_d.fsm = CWS_IDLE; // RULE_17 RULE_02
                s_d.launch = 1'b0; // RULE_07
                s_d.busy = 1'b0;
                s_d.done = 1'b1; // RULE_13
              end
              else
              begin
                s_d.ptr = s_q.ptr + 6'h01; // RULE_02
                s_d.fsm = CWS_FETCH;
              end
            end
          end
        end
      end
      default: s_d.fsm = CWS_IDLE;
    endcase
    // Cancel in any state; a write issued this cycle still goes out, and the pointer stays put
    if (wr_launch && HOST_WR.wdata[`CWS_BIT_CANCEL])
    begin
      s_d.fsm = CWS_IDLE; // RULE_09 RULE_18
      s_d.launch = 1'b0;
      s_d.busy = 1'b0;
      s_d.ptr = s_q.ptr; // RULE_18
    end
    s_d.lock = s_d.busy; // RULE_11
  end

  // State register
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.fsm <= CWS_IDLE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign MAP_RD_ADDR = s_q.last_addr;
  assign RD_BYTE = s_q.rd_byte;
  assign RD_BYTE_VLD = s_q.rd_vld;
  assign CTRL_WR = s_q.ctrl;
  assign HOST_LOCK = s_q.lock;
  assign SEQ_DONE_EVENT = s_q.done;

  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  launch_starts_a: assert property (wr_launch && HOST_WR.wdata[`CWS_BIT_LAUNCH] // RULE_06
    && !HOST_WR.wdata[`CWS_BIT_CANCEL] && s_q.fsm == CWS_IDLE
    |=> s_q.busy && s_q.ptr == $past(HOST_WR.wdata[`CWS_FIRST_MSB:0]))
    else $error("launch did not start run at first step");
  write_follows_fetch_a: assert property (s_q.fsm == CWS_FETCH && run_ok // RULE_01
    && !(wr_launch && HOST_WR.wdata[`CWS_BIT_CANCEL])
    |=> ##1 CTRL_WR.wr && CTRL_WR.addr == $past(fetched.target, 2))
    else $error("step write missing or wrong target");
  field_mask_a: assert property (CTRL_WR.wr |-> (CTRL_WR.data & ~CTRL_WR.mask) == 16'h0000) // RULE_15
    else $error("step data outside field mask");
  done_clears_a: assert property (SEQ_DONE_EVENT |-> !s_q.busy && !s_q.launch && s_q.fsm == CWS_IDLE) // RULE_07
    else $error("done without halt");
  done_after_last_a: assert property (SEQ_DONE_EVENT |-> $past(s_q.cur.last) && $past(s_q.fsm == CWS_WAIT)) // RULE_13
    else $error("done event without last step");
  no_run_disabled_a: assert property (!run_ok && s_q.fsm == CWS_WAIT |=> $stable(s_q.ticks)) // RULE_05
    else $error("sequencer ran while disabled");
  cancel_stops_a: assert property (wr_launch && HOST_WR.wdata[`CWS_BIT_CANCEL] // RULE_09
    |=> !s_q.busy && !s_q.launch && $stable(s_q.ptr))
    else $error("cancel did not stop run");
  lock_busy_a: assert property (HOST_LOCK == (s_q.fsm != CWS_IDLE)) // RULE_11
    else $error("lock differs from sequencer activity");
  busy_word_a: assert property (RD_BYTE_REQ && !RD_ADDR_SET && !HOST_WR.wr && s_q.lsb_phase // RULE_10 RULE_12
    && s_q.last_addr == `CWS_OFS_STAT
    |=> RD_BYTE[`CWS_BIT_BUSY] == $past(s_q.busy) && RD_BYTE[7:`CWS_PTR_LSB] == $past(s_q.ptr[3:0]))
    else $error("status byte wrong");
  byte_order_a: assert property (RD_BYTE_REQ && !RD_ADDR_SET && !HOST_WR.wr && s_q.lsb_phase // RULE_14
    |=> RD_BYTE_VLD && MAP_RD_ADDR == $past(s_q.last_addr) + 8'h01)
    else $error("auto increment after low byte missing");
  step_advance_a: assert property (s_q.fsm == CWS_WAIT && run_ok && s_q.ticks == K_LAST // RULE_02
    && s_q.units == step_units - 16'h0001 && !s_q.cur.last && !(wr_launch && HOST_WR.wdata[`CWS_BIT_CANCEL])
    |=> s_q.fsm == CWS_FETCH && s_q.ptr == $past(s_q.ptr) + 6'h01)
    else $error("step did not advance to next location");

  run_cov_c: cover property (s_q.fsm == CWS_FETCH ##1 s_q.fsm == CWS_WRITE ##1 CTRL_WR.wr);
  done_cov_c: cover property (SEQ_DONE_EVENT);
  cancel_cov_c: cover property (s_q.busy ##1 !s_q.busy && !SEQ_DONE_EVENT);
endmodule

//--- test/cws_regfile_model.sv
// Register file model that the sequencer writes into and the byte reader samples
`timescale 1ns/1ps
module cws_regfile_model (
  input wire logic clk,
  input wire cws_pkg::cws_ctrl_wr_t ctrl_wr,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data
);
  import cws_pkg::*;
  logic [15:0] mem [256];
  // Distinct pattern per register so untouched bits stay visible
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {i[7:0], ~i[7:0]};
  end
  // Masked field update, only the selected bits change
  always @(posedge clk)
    if (ctrl_wr.wr)
      mem[ctrl_wr.addr] <= (mem[ctrl_wr.addr] & ~ctrl_wr.mask) | ctrl_wr.data;
  // Readback is combinational, same cycle
  assign rd_data = mem[rd_addr];
endmodule

//--- test/control_write_sequencer_test.sv
// Self-checking bench of the control write sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (a), (b)); end end
module control_write_sequencer_test;
  import cws_pkg::*;
  logic REF_CLK, RST, SYS_CLK_ENA, RD_ADDR_SET, RD_BYTE_REQ, STEP_LOAD, RD_BYTE_VLD, HOST_LOCK, SEQ_DONE_EVENT;
  cws_host_wr_t HOST_WR;
  cws_step_t STEP_DESC;
  cws_ctrl_wr_t CTRL_WR;
  logic [15:0] MAP_RD_DATA;
  logic [7:0] MAP_RD_ADDR, RD_BYTE;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // Short time unit keeps step waits small
  cws_sequencer #(.K_CYCLES(2)) u_dut (.REF_CLK, .RST, .SYS_CLK_ENA, .HOST_WR, .RD_ADDR_SET, .RD_BYTE_REQ,
    .MAP_RD_DATA, .STEP_LOAD, .STEP_DESC, .MAP_RD_ADDR, .RD_BYTE, .RD_BYTE_VLD, .CTRL_WR, .HOST_LOCK, .SEQ_DONE_EVENT);
  cws_regfile_model u_regs (.clk(REF_CLK), .ctrl_wr(CTRL_WR), .rd_addr(MAP_RD_ADDR), .rd_data(MAP_RD_DATA));
  // 25 MHz clock
  initial
  begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  // Hang guard
  always @(posedge REF_CLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge REF_CLK) HOST_WR = '{1'b1, a, d};
    @(negedge REF_CLK) HOST_WR.wr = 1'b0;
  endtask
  task automatic ld(input cws_step_t s);
    @(negedge REF_CLK) STEP_DESC = s;
    STEP_LOAD = 1'b1;
    @(negedge REF_CLK) STEP_LOAD = 1'b0;
  endtask
  // Two byte requests, MSB first
  task automatic rd_word(input logic [15:0] exp);
    logic [15:0] w;
    w = '0;
    repeat (2)
    begin
      @(negedge REF_CLK) RD_BYTE_REQ = 1'b1;
      @(negedge REF_CLK) RD_BYTE_REQ = 1'b0;
      // Valid stands only in the cycle right after the request
      `CHK(RD_BYTE_VLD, 1'b1)
      w = {w[7:0], RD_BYTE};
    end
    `CHK(w, exp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge REF_CLK) HOST_WR.addr = a;
    RD_ADDR_SET = 1'b1;
    @(negedge REF_CLK) RD_ADDR_SET = 1'b0;
    rd_word(exp);
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (HOST_LOCK === 1'b1 && n < 3000)
    begin
      @(negedge REF_CLK);
      n++;
    end
  endtask
  task automatic t_regs();
    rd(8'h6C, 16'h0000);
    rd(8'h6F, 16'h0000);
    wr(8'h70, 16'h03F1);
    rd(8'h70, 16'h0000);
    wr(8'h6C, 16'h011F);
    rd(8'h6C, 16'h011F);
    $display("test regs done");
  endtask
  task automatic t_run();
    int n;
    ld('{1'b0, 4'h1, 3'h1, 4'h1, 8'h05, 8'h03});
    ld('{1'b1, 4'h0, 3'h7, 4'h8, 8'h06, 8'h3C});
    wr(8'h6F, 16'h0105);
    `CHK(HOST_LOCK, 1'b1)
    wait_idle(n);
    `CHK(n, 42)
    `CHK(SEQ_DONE_EVENT, 1'b1)
    @(negedge REF_CLK);
    `CHK(SEQ_DONE_EVENT, 1'b0)
    `CHK(u_regs.mem[5], 16'h05FE)
    `CHK(u_regs.mem[6], 16'h3CF9)
    rd(8'h6F, 16'h0005);
    rd(8'h70, 16'h0060);
    $display("test run done");
  endtask
  task automatic t_cancel();
    ld('{1'b0, 4'h6, 3'h0, 4'h0, 8'h07, 8'h01});
    wr(8'h6F, 16'h0107);
    repeat (8) @(negedge REF_CLK);
    rd(8'h70, 16'h0071);
    wr(8'h6F, 16'h0207);
    repeat (2) @(negedge REF_CLK);
    `CHK(HOST_LOCK, 1'b0)
    `CHK(u_regs.mem[7], 16'h07F9)
    rd(8'h70, 16'h0070);
    rd(8'h6F, 16'h0007);
    // Cancel landing in the write cycle: the write still completes, then the run stops
    ld('{1'b0, 4'h6, 3'h3, 4'h4, 8'h08, 8'h0A});
    wr(8'h6F, 16'h0108);
    wr(8'h6F, 16'h0208);
    repeat (2) @(negedge REF_CLK);
    `CHK(HOST_LOCK, 1'b0)
    `CHK(u_regs.mem[8], 16'h08A7)
    rd(8'h70, 16'h0080);
    $display("test cancel done");
  endtask
  task automatic t_freeze();
    int n;
    wr(8'h6C, 16'h0000);
    wr(8'h6F, 16'h0106);
    repeat (30) @(negedge REF_CLK);
    `CHK(HOST_LOCK, 1'b1)
    SYS_CLK_ENA = 1'b0;
    wr(8'h6C, 16'h0100);
    repeat (30) @(negedge REF_CLK);
    `CHK(HOST_LOCK, 1'b1)
    SYS_CLK_ENA = 1'b1;
    // Four edges bring the step into its wait, then the clock enable drops again
    repeat (4) @(negedge REF_CLK);
    SYS_CLK_ENA = 1'b0;
    repeat (10) @(negedge REF_CLK);
    `CHK(HOST_LOCK, 1'b1)
    SYS_CLK_ENA = 1'b1;
    wait_idle(n);
    // Twenty busy edges for a zero wait code step, four already spent
    `CHK(n, 16)
    $display("test freeze done");
  endtask
  task automatic t_rom();
    logic [5:0] ix [4] = '{6'd31, 6'd32, 6'd48, 6'd63};
    int n;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h6F, {8'h01, 2'b00, ix[i]});
      wait_idle(n);
      `CHK(n, 20)
      rd(8'h70, {6'h00, ix[i], 4'h0});
    end
    $display("test rom done");
  endtask
  task automatic t_burst();
    rd(8'h6E, 16'h6E91);
    rd_word(16'h003F);
    rd_word(16'h03F0);
    rd(8'hFF, 16'hFF00);
    rd_word(16'h00FF);
    $display("test burst done");
  endtask
  // Reset, then the scenarios in order
  initial
  begin
    RST = 1'b1;
    SYS_CLK_ENA = 1'b1;
    HOST_WR = '0;
    RD_ADDR_SET = 1'b0;
    RD_BYTE_REQ = 1'b0;
    STEP_LOAD = 1'b0;
    STEP_DESC = '0;
    repeat (6) @(negedge REF_CLK);
    RST = 1'b0;
    t_regs();
    t_run();
    t_cancel();
    t_freeze();
    t_rom();
    t_burst();
    print_verdict();
  end
endmodule
